// ---- verification/pag_pin_model.sv ----
`timescale 1ns/1ps
// The pins resolve in this order: device drive, then outside source, then weak pull-up.
module pag_pin_model (
	// Clock
	input  wire logic       clk,
	// Device side
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe_n,
	input  wire logic [7:0] pin_pullup,
	// Outside source
	input  wire logic [7:0] ext_val,
	input  wire logic [7:0] ext_en,
	// Resolved levels
	output logic      [7:0] level
);
	logic [7:0] float_reg = 8'h5A;

	// A floating pin wanders every cycle so it cannot pass for a driven value.
	always @(posedge clk) begin
		float_reg <= ~float_reg;
	end

	assign level = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
		| (pin_oe_n & ~ext_en & (pin_pullup | float_reg));
endmodule : pag_pin_model

// ---- verification/test_port_a_gpio_block.sv ----
`timescale 1ns/1ps
`include "pag_consts.svh"
module test_port_a_gpio_block;
	logic        clk     = 1'b0;
	logic        rst     = 1'b1;
	logic        cyc     = 1'b0;
	logic        wb_we   = 1'b0;
	logic [7:0]  wb_adr  = 8'h00;
	logic [31:0] wb_wdat = 32'h0;
	logic        strap   = 1'b1;
	logic [7:0]  ext_val = 8'h00;
	logic [7:0]  ext_en  = 8'hFF;
	logic [7:0]  a1o     = 8'h00;
	logic [7:0]  a1e     = 8'h00;
	logic [7:0]  a2o     = 8'h00;
	logic [7:0]  a2e     = 8'h00;
	logic [31:0] rdat;
	logic        ack;
	logic        chg;
	logic [7:0]  lvl;
	logic [7:0]  pout;
	logic [7:0]  oe_n;
	logic [7:0]  pu;
	logic [7:0]  dig;
	logic [7:0]  exp_q[$];
	logic [7:0]  v;
	logic [7:0]  m1;
	logic [7:0]  m2;
	logic [7:0]  val;
	logic [7:0]  eoe;
	int          errors    = 0;
	int          tests_run = 0;
	int          seed      = 79;
	int          cycles    = 0;

	always #20 clk = ~clk;

	pag_top pag_top_inst (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .pin_in(lvl), .pin_out(pout), .pin_oe_n(oe_n),
		.pin_pullup(pu), .alt1_out(a1o), .alt1_en(a1e), .alt2_out(a2o), .alt2_en(a2e),
		.external_reset_input_sel(strap), .port_a_digital_in(dig), .change_event(chg));

	pag_pin_model pag_pin_model_inst (.clk(clk), .pin_out(pout), .pin_oe_n(oe_n),
		.pin_pullup(pu), .ext_val(ext_val), .ext_en(ext_en), .level(lvl));

	task automatic check(input string name, input logic [7:0] e, input logic [7:0] s);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, e, s);
		end
	endtask : check

	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test

	task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_wdat <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			check("bus ack", 8'h01, 8'h00);
			end_of_test();
		end
		cyc <= 1'b0;
	endtask : bus

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 8'h00);
	endtask : rd

	// Reads are judged where the answer lands, in arrival order.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0) begin
			check("read data", exp_q.pop_front(), rdat[7:0]);
			check("read high", 8'h00, rdat[31:24] | rdat[23:16] | rdat[15:8]);
		end
		if (cycles == 5000) begin
			errors++;
			end_of_test();
		end
	end

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(`PAG_ADR_DIRECTION, 8'hFF);
		rd(`PAG_ADR_ANALOG, 8'h0F);
		rd(`PAG_ADR_IRQ_EN, 8'h00);
		rd(`PAG_ADR_PULLUP, 8'h2F);
		rd(`PAG_ADR_OPTION, 8'h81);
		rd(8'h20, 8'h00);
		check("oe_n at reset", 8'hFF, oe_n);
		check("pullup at reset", 8'h20, pu);
		// Direction bit five is forced to one, so an all-zero write re-reads as 8'h20.
		bus(1'b1, `PAG_ADR_DIRECTION, 8'h00);
		rd(`PAG_ADR_DIRECTION, 8'h20);
		v = 8'($random(seed)) & 8'hCF;
		eoe = 8'h20 | (v & 8'h80);
		ext_en <= eoe;
		ext_val <= 8'($random(seed));
		a1e <= 8'($random(seed));
		a2e <= 8'($random(seed));
		bus(1'b1, `PAG_ADR_VALUE, v);
		repeat (8) @(posedge clk);
		check("oe_n latch", eoe, oe_n);
		check("pin_out latch", v & ~eoe, pout & ~eoe);
		rd(`PAG_ADR_VALUE, ((v & ~eoe) | (ext_val & eoe)) & 8'hF0);
		bus(1'b1, `PAG_ADR_ANALOG, 8'h00);
		repeat (8) @(posedge clk);
		rd(`PAG_ADR_VALUE, (v & ~eoe) | (ext_val & eoe));
		check("digital in", (v & ~eoe) | (ext_val & eoe), dig);
		bus(1'b1, `PAG_ADR_OWNER, 8'h00);
		bus(1'b1, `PAG_ADR_ANALOG, 8'h0F);
		for (int k = 0; k < 6; k++) begin
			@(posedge clk);
			a1o <= 8'($random(seed));
			a1e <= 8'($random(seed));
			a2o <= 8'($random(seed));
			a2e <= 8'($random(seed));
			repeat (3) @(posedge clk);
			m1 = a1e & `PAG_ALT1_MASK;
			m2 = a2e & `PAG_ALT2_MASK & ~m1;
			val = (m1 & a1o) | (m2 & a2o);
			eoe = ~(m1 | m2) | 8'h20 | (val & `PAG_OPEN_DRAIN);
			check("oe_n function", eoe, oe_n);
			check("pin_out function", val & ~eoe, pout & ~eoe);
		end
		a1e <= 8'h00;
		a2e <= 8'h00;
		ext_en <= 8'hFF;
		bus(1'b1, `PAG_ADR_DIRECTION, 8'hFF);
		bus(1'b1, `PAG_ADR_OPTION, 8'h00);
		repeat (2) @(posedge clk);
		check("pullup analog", 8'h20, pu);
		bus(1'b1, `PAG_ADR_ANALOG, 8'h00);
		repeat (2) @(posedge clk);
		check("pullup input", 8'h2F, pu);
		bus(1'b1, `PAG_ADR_DIRECTION, 8'hF5);
		repeat (2) @(posedge clk);
		check("pullup output", 8'h25, pu);
		bus(1'b1, `PAG_ADR_IRQ_EN, 8'hFF);
		rd(`PAG_ADR_IRQ_EN, 8'hFF);
		repeat (8) @(posedge clk);
		ext_val <= ext_val ^ 8'h40;
		m1 = 8'h00;
		for (int n = 0; n < 12; n++) begin
			@(posedge clk);
			if (chg === 1'b1) m1 = 8'h01;
		end
		check("change event", 8'h01, m1);
		rd(`PAG_ADR_CHANGE, 8'h40);
		bus(1'b1, `PAG_ADR_CHANGE, 8'h40);
		rd(`PAG_ADR_CHANGE, 8'h00);
		// A second reset with the strap low: pin five must lose its pull-up.
		strap <= 1'b0;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(`PAG_ADR_IRQ_EN, 8'h00);
		rd(`PAG_ADR_CHANGE, 8'h00);
		rd(`PAG_ADR_OPTION, 8'h80);
		check("pullup strap off", 8'h00, pu);
		end_of_test();
	end
endmodule : test_port_a_gpio_block

// ---- verilog/pag_consts.svh ----
`ifndef PAG_CONSTS_SVH
`define PAG_CONSTS_SVH
`define PAG_ADR_VALUE      8'h00
`define PAG_ADR_DIRECTION  8'h04
`define PAG_ADR_ANALOG     8'h08
`define PAG_ADR_IRQ_EN     8'h0C
`define PAG_ADR_PULLUP     8'h10
`define PAG_ADR_OPTION     8'h14
`define PAG_ADR_OWNER      8'h18
`define PAG_ADR_CHANGE     8'h1C
`define PAG_RST_DIRECTION  8'hFF
`define PAG_RST_ANALOG     4'hF
`define PAG_RST_IRQ_EN     8'h00
`define PAG_RST_PULLUP     8'h2F
`define PAG_RST_OWNER      8'hFF
`define PAG_RST_LATCH      8'h00
`define PAG_VALUE_RW_MASK  8'hCF
`define PAG_INPUT_ONLY_BIT 5
`define PAG_PULLUP_MASK    8'h2F
`define PAG_OPEN_DRAIN     8'h90
`define PAG_ALT1_MASK      8'hC7
`define PAG_ALT2_MASK      8'h84
`define PAG_OPT_GDIS_BIT   7
`define PAG_OPT_XRST_BIT   0
`endif

// ---- verilog/pag_pin_if.sv ----
`timescale 1ns/1ps
interface pag_pin_if;
	pag_pkg::pag_byte_type latch;
	pag_pkg::pag_byte_type direction;
	pag_pkg::pag_byte_type analog;
	pag_pkg::pag_byte_type pullup_en;
	pag_pkg::pag_byte_type owner;
	logic                  gdis;
	logic                  xrst_sel;
	modport ctrl (output latch, direction, analog, pullup_en, owner, gdis, xrst_sel);
	modport mux (input latch, direction, analog, pullup_en, owner, gdis, xrst_sel);
endinterface : pag_pin_if

// ---- verilog/pag_pin_mux.sv ----
`timescale 1ns/1ps
`include "pag_consts.svh"
module pag_pin_mux (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Port control
	pag_pin_if.mux          io,
	// Peripheral outputs
	input  wire logic [7:0] alt1_out,
	input  wire logic [7:0] alt1_en,
	input  wire logic [7:0] alt2_out,
	input  wire logic [7:0] alt2_en,
	// Pins
	output logic      [7:0] pin_out,
	output logic      [7:0] pin_oe_n,
	output logic      [7:0] pin_pullup
);
	logic [7:0] a1;
	logic [7:0] a2;
	logic [7:0] any_fn;
	logic [7:0] drive;
	logic [7:0] val;
	logic [7:0] od;
	logic [7:0] pull;

	assign a1 = alt1_en & `PAG_ALT1_MASK;
	assign a2 = alt2_en & `PAG_ALT2_MASK;
	assign any_fn = io.owner | a1 | a2;
	assign drive = ~io.direction & any_fn;
	assign val = (io.owner & io.latch) | (~io.owner & a1 & alt1_out)
		| (~io.owner & ~a1 & alt2_out);
	assign od = `PAG_OPEN_DRAIN;

	always_comb begin
		pull = `PAG_PULLUP_MASK & io.pullup_en & io.direction & ~io.analog
			& ~a1 & ~a2 & {8{~io.gdis}};
		pull[`PAG_INPUT_ONLY_BIT] = io.xrst_sel;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_out    <= '0;
			pin_oe_n   <= 8'hFF;
			pin_pullup <= '0;
		end else begin
			pin_out    <= val & ~od;
			pin_oe_n   <= ~(drive & (~od | ~val));
			pin_pullup <= pull;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_od_low;
		(pin_out & od) == 8'h00;
	endproperty
	a_od_low : assert property (p_od_low) else $error("open-drain pin driven high");
	property p_input_quiet;
		!rst ##1 1'b1 |-> (pin_oe_n | ~$past(io.direction)) == 8'hFF;
	endproperty
	a_input_quiet : assert property (p_input_quiet) else $error("input pin driven");
	property p_no_pull;
		(pin_pullup & 8'hD0) == 8'h00;
	endproperty
	a_no_pull : assert property (p_no_pull) else $error("pull-up on pin without one");
	property p_pull_off_out;
		!rst ##1 1'b1 |-> (pin_pullup & ~$past(io.direction) & 8'h0F) == 8'h00;
	endproperty
	a_pull_off_out : assert property (p_pull_off_out) else $error("pull-up on output");
	c_alt_drive : cover property (~io.owner[7] && alt1_en[7] && !io.direction[7] ##1 1'b1);
endmodule : pag_pin_mux

// ---- verilog/pag_pkg.sv ----
package pag_pkg;
	typedef logic [7:0] pag_byte_type;
	typedef enum {
		PAG_SEL_VALUE, PAG_SEL_DIRECTION, PAG_SEL_ANALOG, PAG_SEL_IRQ_EN,
		PAG_SEL_PULLUP, PAG_SEL_OPTION, PAG_SEL_OWNER, PAG_SEL_CHANGE, PAG_SEL_NONE
	} pag_sel_type;
endpackage : pag_pkg

// ---- verilog/pag_sync.sv ----
`timescale 1ns/1ps
module pag_sync #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] agree;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	assign agree = ~(s2_reg ^ s3_reg);

	// A bit moves only once two stages agree, which filters a single stray sample.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= (agree & s3_reg) | (~agree & q);
		end
	end
endmodule : pag_sync

// ---- verilog/pag_top.sv ----
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "pag_consts.svh"
// Contract
// - Direction one disables driver, zero drives
// - Pin five direction always reads one
// - Value read shows pins, write hits latch
// - Value writes are read-modify-write
// - Direction governs drivers even in analog
// - Analog-selected pins read zero digitally
// - Output pins read back actual level
// - Per-pin change enables, cleared at reset
// - Pull-ups only on pins 3-0 and 5
// - Pull-up off for outputs, functions, disable, except pin five
// - Pin five pull-up follows reset strap
// - Analog select never blocks digital output
// - Analog select resets to analog mode
// - Pins seven and four only pull low
// - Highest priority enabled function owns pin
// - Fixed per-pin output priority order
// - Functions drive pins in analog mode
// - Eight pins: push-pull, open-drain, input-only
// - Value bits five, four read-only
// - Pull-up needs enable, input, bit, digital, except pin five
// - Analog disables input, pull-up, change
module pag_top (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Pins
	input  wire logic [7:0]  pin_in,
	output logic      [7:0]  pin_out,
	output logic      [7:0]  pin_oe_n,
	output logic      [7:0]  pin_pullup,
	// Peripheral outputs, two levels below the latch
	input  wire logic [7:0]  alt1_out,
	input  wire logic [7:0]  alt1_en,
	input  wire logic [7:0]  alt2_out,
	input  wire logic [7:0]  alt2_en,
	// Configuration strap and peripheral side
	input  wire logic        external_reset_input_sel,
	output logic      [7:0]  port_a_digital_in,
	output logic             change_event
);
	pag_pin_if io ();

	pag_pkg::pag_byte_type latch_reg;
	pag_pkg::pag_byte_type port_a_direction_reg;
	logic [3:0]            port_a_analog_select_reg;
	pag_pkg::pag_byte_type port_a_change_irq_enable_reg;
	pag_pkg::pag_byte_type port_a_pullup_enable_reg;
	logic                  pullup_global_disable_reg;
	pag_pkg::pag_byte_type owner_reg;
	pag_pkg::pag_byte_type change_flag_reg;
	pag_pkg::pag_byte_type prev_reg;
	logic                  xrst_sel_reg;
	logic                  strap_done_reg;
	pag_pkg::pag_byte_type sync_pins;
	pag_pkg::pag_byte_type analog8;
	pag_pkg::pag_byte_type value_read;
	pag_pkg::pag_byte_type changed;
	pag_pkg::pag_byte_type rdata;
	pag_pkg::pag_sel_type  sel;
	logic                  req;
	logic                  wr;

	pag_sync #(
		.W (8)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.d   (pin_in),
		.q   (sync_pins)
	);

	pag_pin_mux u_mux (
		.clk        (clk),
		.rst        (rst),
		.io         (io.mux),
		.alt1_out   (alt1_out),
		.alt1_en    (alt1_en),
		.alt2_out   (alt2_out),
		.alt2_en    (alt2_en),
		.pin_out    (pin_out),
		.pin_oe_n   (pin_oe_n),
		.pin_pullup (pin_pullup)
	);

	assign io.latch     = latch_reg;
	assign io.direction = port_a_direction_reg;
	assign io.analog    = analog8;
	assign io.pullup_en = port_a_pullup_enable_reg;
	assign io.owner     = owner_reg;
	assign io.gdis      = pullup_global_disable_reg;
	assign io.xrst_sel  = xrst_sel_reg;

	assign analog8 = {4'h0, port_a_analog_select_reg};
	// Driven output pins read back through the same path, so contention shows.
	assign value_read = sync_pins & ~analog8;

	// One request per cycle; ack is held off in the answer cycle so it lasts one cycle.
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = req & wb_we_i & wb_sel_i[0];

	always_comb begin
		if (wb_adr_i == `PAG_ADR_VALUE) begin
			sel = pag_pkg::PAG_SEL_VALUE;
		end else if (wb_adr_i == `PAG_ADR_DIRECTION) begin
			sel = pag_pkg::PAG_SEL_DIRECTION;
		end else if (wb_adr_i == `PAG_ADR_ANALOG) begin
			sel = pag_pkg::PAG_SEL_ANALOG;
		end else if (wb_adr_i == `PAG_ADR_IRQ_EN) begin
			sel = pag_pkg::PAG_SEL_IRQ_EN;
		end else if (wb_adr_i == `PAG_ADR_PULLUP) begin
			sel = pag_pkg::PAG_SEL_PULLUP;
		end else if (wb_adr_i == `PAG_ADR_OPTION) begin
			sel = pag_pkg::PAG_SEL_OPTION;
		end else if (wb_adr_i == `PAG_ADR_OWNER) begin
			sel = pag_pkg::PAG_SEL_OWNER;
		end else if (wb_adr_i == `PAG_ADR_CHANGE) begin
			sel = pag_pkg::PAG_SEL_CHANGE;
		end else begin
			sel = pag_pkg::PAG_SEL_NONE;
		end
	end

	always_comb begin
		case (sel)
			pag_pkg::PAG_SEL_VALUE:     rdata = value_read;
			pag_pkg::PAG_SEL_DIRECTION: rdata = port_a_direction_reg;
			pag_pkg::PAG_SEL_ANALOG:    rdata = analog8;
			pag_pkg::PAG_SEL_IRQ_EN:    rdata = port_a_change_irq_enable_reg;
			pag_pkg::PAG_SEL_PULLUP:    rdata = port_a_pullup_enable_reg;
			pag_pkg::PAG_SEL_OPTION:    rdata = {pullup_global_disable_reg, 6'h00, xrst_sel_reg};
			pag_pkg::PAG_SEL_OWNER:     rdata = owner_reg;
			pag_pkg::PAG_SEL_CHANGE:    rdata = change_flag_reg;
			default:                    rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			if (req && !wb_we_i) begin
				wb_dat_o <= {24'h00_0000, rdata};
			end
		end
	end

	// Read-only bits take the level just read, as a read-modify-write would leave them.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latch_reg <= `PAG_RST_LATCH;
		end else if (wr && sel == pag_pkg::PAG_SEL_VALUE) begin
			latch_reg <= (wb_dat_i[7:0] & `PAG_VALUE_RW_MASK)
				| (value_read & ~`PAG_VALUE_RW_MASK);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			port_a_direction_reg <= `PAG_RST_DIRECTION;
		end else if (wr && sel == pag_pkg::PAG_SEL_DIRECTION) begin
			port_a_direction_reg <= wb_dat_i[7:0];
			port_a_direction_reg[`PAG_INPUT_ONLY_BIT] <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			port_a_analog_select_reg <= `PAG_RST_ANALOG;
		end else if (wr && sel == pag_pkg::PAG_SEL_ANALOG) begin
			port_a_analog_select_reg <= wb_dat_i[3:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			port_a_change_irq_enable_reg <= `PAG_RST_IRQ_EN;
		end else if (wr && sel == pag_pkg::PAG_SEL_IRQ_EN) begin
			port_a_change_irq_enable_reg <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			port_a_pullup_enable_reg <= `PAG_RST_PULLUP;
		end else if (wr && sel == pag_pkg::PAG_SEL_PULLUP) begin
			port_a_pullup_enable_reg <= wb_dat_i[7:0] & `PAG_PULLUP_MASK;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pullup_global_disable_reg <= 1'b1;
		end else if (wr && sel == pag_pkg::PAG_SEL_OPTION) begin
			pullup_global_disable_reg <= wb_dat_i[`PAG_OPT_GDIS_BIT];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			owner_reg <= `PAG_RST_OWNER;
		end else if (wr && sel == pag_pkg::PAG_SEL_OWNER) begin
			owner_reg <= wb_dat_i[7:0];
		end
	end

	// The strap is taken once, on the first edge after reset, and held until next reset.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			xrst_sel_reg   <= 1'b0;
			strap_done_reg <= 1'b0;
		end else if (!strap_done_reg) begin
			xrst_sel_reg   <= external_reset_input_sel;
			strap_done_reg <= 1'b1;
		end
	end

	assign changed = (value_read ^ prev_reg) & port_a_change_irq_enable_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_reg     <= 8'h00;
			change_event <= 1'b0;
		end else begin
			prev_reg     <= value_read;
			change_event <= |changed;
		end
	end

	// A change seen in the clearing cycle survives: set is applied after the clear.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			change_flag_reg <= 8'h00;
		end else if (wr && sel == pag_pkg::PAG_SEL_CHANGE) begin
			change_flag_reg <= (change_flag_reg & ~wb_dat_i[7:0]) | changed;
		end else begin
			change_flag_reg <= change_flag_reg | changed;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			port_a_digital_in <= 8'h00;
		end else begin
			port_a_digital_in <= value_read;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_dir5;
		port_a_direction_reg[`PAG_INPUT_ONLY_BIT] == 1'b1;
	endproperty
	a_dir5 : assert property (p_dir5) else $error("input-only direction bit cleared");

	property p_analog_zero;
		req && !wb_we_i && sel == pag_pkg::PAG_SEL_VALUE
			|=> (wb_dat_o[3:0] & port_a_analog_select_reg) == 4'h0;
	endproperty
	a_analog_zero : assert property (p_analog_zero) else $error("analog pin read as one");

	property p_ro_bits;
		wr && sel == pag_pkg::PAG_SEL_VALUE |=> latch_reg[5:4] == $past(value_read[5:4]);
	endproperty
	a_ro_bits : assert property (p_ro_bits) else $error("read-only value bits written");

	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse : assert property (p_ack_pulse) else $error("ack held longer than one cycle");

	property p_ack_next;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next : assert property (p_ack_next) else $error("ack not given next cycle");

	property p_sync;
		!$past(rst) ##0 $stable(pin_in)[*5] |-> sync_pins == pin_in;
	endproperty
	a_sync : assert property (p_sync) else $error("synchronised pins lag a steady input");

	property p_change_flag;
		changed != 8'h00 |=> (change_flag_reg & $past(changed)) == $past(changed) && change_event;
	endproperty
	a_change_flag : assert property (p_change_flag) else $error("change not flagged");

	property p_strap;
		$rose(strap_done_reg) |-> xrst_sel_reg == $past(external_reset_input_sel);
	endproperty
	a_strap : assert property (p_strap) else $error("strap not captured");

	property p_pull_mask;
		(port_a_pullup_enable_reg & ~`PAG_PULLUP_MASK) == 8'h00;
	endproperty
	a_pull_mask : assert property (p_pull_mask) else $error("pull-up bit on bare pin");

	property p_read_high;
		wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000;
	endproperty
	a_read_high : assert property (p_read_high) else $error("read data upper bits set");

	property p_dig_analog;
		(port_a_digital_in[3:0] & $past(port_a_analog_select_reg)) == 4'h0;
	endproperty
	a_dig_analog : assert property (p_dig_analog) else $error("analog pin read high");

	property p_evt_en;
		change_event |-> $past(port_a_change_irq_enable_reg) != 8'h00;
	endproperty
	a_evt_en : assert property (p_evt_en) else $error("change event while disabled");

	property p_unmapped;
		req && !wb_we_i && sel == pag_pkg::PAG_SEL_NONE |=> wb_dat_o == 32'h0000_0000;
	endproperty
	a_unmapped : assert property (p_unmapped) else $error("unmapped read not zero");

	// A clear that meets a fresh change keeps that bit, so only quiet bits must drop.
	property p_w1c;
		wr && sel == pag_pkg::PAG_SEL_CHANGE
			|=> (change_flag_reg & $past(wb_dat_i[7:0]) & ~$past(changed)) == 8'h00;
	endproperty
	a_w1c : assert property (p_w1c) else $error("change flag not cleared");

	c_read_value : cover property (req && !wb_we_i && sel == pag_pkg::PAG_SEL_VALUE);
	c_write_value : cover property (wr && sel == pag_pkg::PAG_SEL_VALUE);
	c_change : cover property (change_event);
	c_w1c_clear : cover property (wr && sel == pag_pkg::PAG_SEL_CHANGE);
endmodule : pag_top
